// File: design/itr_intertrip_logic.sv
`default_nettype none

// ------------------------------------------------------------
// intertrip and remote trip: transmit and receive per phase
// ------------------------------------------------------------
module itr_intertrip_logic
    import itr_pkg::*;
#(
    parameter int TICK_CYCLES = itr_pkg::ITR_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [itr_pkg::ITR_ADDR_W-1:0] regAddr,
    input wire logic [itr_pkg::ITR_DATA_W-1:0] regWrData,
    input wire logic regWrStrobe,
    input wire logic regRdStrobe,
    output logic [itr_pkg::ITR_DATA_W-1:0] regRdData,
    output logic irq,
    // local differential trips, same clock
    input wire logic [itr_pkg::ITR_PHASES-1:0] diffTrip,
    // binary input pins, asynchronous
    input wire logic [itr_pkg::ITR_PHASES-1:0] remoteTripInPhase,
    input wire logic remoteTripInAllPhases,
    // commands received over protection link one, same clock
    input wire logic [itr_pkg::ITR_PHASES-1:0] rxCmd,
    // commands to send over protection link one
    output logic [itr_pkg::ITR_PHASES-1:0] txCmd,
    // indications
    output logic [itr_pkg::ITR_PHASES-1:0] rxCmdInd,
    output logic [itr_pkg::ITR_PHASES-1:0] txCmdInd,
    output logic [itr_pkg::ITR_PHASES-1:0] tripForward,
    output logic [itr_pkg::ITR_PHASES-1:0] rxAlarm,
    output itr_pkg::itr_trip_ind_t tripInd
);
    import itr_pkg::*;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // divider width
    localparam int TICK_W = $clog2(TICK_CYCLES + 1);

    // zero divider never ticks, stalling every timer
    if (TICK_CYCLES < 1) begin : gTickCheck
        $error("TICK_CYCLES must be at least one");
    end

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    // settings and events
    itr_cfg_t cfgReg; // software settings
    logic [ITR_EVT_W-1:0] statusReg; // sticky events, cleared on read
    logic [ITR_EVT_W-1:0] statusNext;
    logic [ITR_EVT_W-1:0] maskReg; // interrupt enables
    logic [ITR_EVT_W-1:0] events; // one-cycle event pulses

    // time base
    logic [TICK_W-1:0] tickCntReg; // divider toward the time base
    logic tickReg; // one-cycle pulse every base period

    // transmit side
    logic [ITR_PHASES:0] pinSync; // synchronised binary inputs
    logic [ITR_PHASES-1:0] biRequest; // per-phase binary request
    logic [ITR_PHASES-1:0] biActive; // after delay and prolongation
    logic [ITR_PHASES-1:0] txNext;

    // edge memory for the events
    logic [ITR_PHASES-1:0] rxSeenReg; // previous rx for edge events
    logic [ITR_PHASES-1:0] txSeenReg; // previous tx for edge events

    // receive side
    logic reactTrip;
    logic [1:0] rxCount; // number of phases received

    // bus decode
    logic wrHit;
    logic rdStatus;
    logic [ITR_TIME_W-1:0] wrTime; // write data clamped to 30 s

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    // no wait states; writes land on their strobe edge
    assign wrHit = regWrStrobe;

    // larger values are clamped rather than wrapped, so a bad write
    // can only lengthen a timer to its top value
    assign wrTime = (regWrData[ITR_DATA_W-1:ITR_TIME_W] != '0
        || regWrData[ITR_TIME_W-1:0] > ITR_TIME_MAX)
        ? ITR_TIME_MAX : regWrData[ITR_TIME_W-1:0];

    // settings; the defaults give send off and trip reaction
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfgReg.sendDiff <= 1'b0;
            cfgReg.react <= ITR_REACT_TRIP;
            cfgReg.pickup <= ITR_PICKUP_RST;
            cfgReg.prolong <= ITR_PROLONG_RST;
        end else if (wrHit) begin
            case (regAddr)
                // send enable and reaction in one word
                ITR_OFS_CTRL: begin
                    cfgReg.sendDiff <= regWrData[ITR_CTRL_SEND_BIT];
                    cfgReg.react <= itr_react_t'(regWrData[ITR_CTRL_ALARM_BIT]);
                end
                // pickup delay in base ticks
                ITR_OFS_PICKUP: begin
                    cfgReg.pickup <= wrTime;
                end
                // prolongation in base ticks
                ITR_OFS_PROLONG: begin
                    cfgReg.prolong <= wrTime;
                end
                // other offsets, the mask aside, hold nothing writable
                default: begin
                    cfgReg <= cfgReg;
                end
            endcase
        end
    end

    // interrupt mask
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            maskReg <= '0;
        end else if (wrHit && regAddr == ITR_OFS_MASK) begin
            maskReg <= regWrData[ITR_EVT_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    // reading status is what clears it
    assign rdStatus = regRdStrobe && (regAddr == ITR_OFS_STATUS);

    // read data stands for one cycle only, zero otherwise
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdData <= '0;
        end else begin
            regRdData <= '0;
            if (regRdStrobe) begin
                case (regAddr)
                    // settings read back as written
                    ITR_OFS_CTRL: begin
                        regRdData[ITR_CTRL_SEND_BIT] <= cfgReg.sendDiff;
                        regRdData[ITR_CTRL_ALARM_BIT] <= cfgReg.react;
                    end
                    // base ticks, upper bits zero
                    ITR_OFS_PICKUP: begin
                        regRdData[ITR_TIME_W-1:0] <= cfgReg.pickup;
                    end
                    ITR_OFS_PROLONG: begin
                        regRdData[ITR_TIME_W-1:0] <= cfgReg.prolong;
                    end
                    // sticky events; includes one arriving right now
                    ITR_OFS_STATUS: begin
                        regRdData[ITR_EVT_W-1:0] <= statusReg | events;
                    end
                    // interrupt enables
                    ITR_OFS_MASK: begin
                        regRdData[ITR_EVT_W-1:0] <= maskReg;
                    end
                    // live indications of the block
                    ITR_OFS_STATE: begin
                        regRdData[ITR_EVT_RX_LSB +: ITR_PHASES] <= rxCmdInd;
                        regRdData[ITR_EVT_TX_LSB +: ITR_PHASES] <= txCmdInd;
                        regRdData[ITR_STATE_GEN_BIT] <= tripInd.general;
                    end
                    // unmapped addresses read as zero
                    default: begin
                        regRdData <= '0;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // time base
    // ------------------------------------------------------------
    // one tick per base period keeps the timers at 0.01 s steps
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tickCntReg <= '0;
            tickReg <= 1'b0;
        end else if (tickCntReg == TICK_W'(TICK_CYCLES - 1)) begin
            tickCntReg <= '0;
            tickReg <= 1'b1;
        end else begin
            tickCntReg <= tickCntReg + 1'b1;
            tickReg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // transmit path
    // ------------------------------------------------------------
    // binary inputs are wired from the field, so they are synchronised
    // top bit is the three-pole input
    itr_pin_sync #(
        .WIDTH(ITR_PHASES + 1)
    ) uPinSync (
        .clk(clk),
        .rst(rst),
        .pinIn({remoteTripInAllPhases, remoteTripInPhase}),
        .syncOut(pinSync)
    );

    // own phase input, or the three-pole input for every phase
    assign biRequest = pinSync[ITR_PHASES-1:0]
        | {ITR_PHASES{pinSync[ITR_PHASES]}};

    // one delay and prolongation timer per phase; a request shorter
    // than the delay never reaches the link
    // the timers share one set of settings
    for (genvar p = 0; p < ITR_PHASES; p++) begin : gPhase
        itr_phase_timer #(
            .TW(ITR_TIME_W)
        ) uTimer (
            .clk(clk),
            .rst(rst),
            .tick(tickReg),
            .reqIn(biRequest[p]),
            .pickupTicks(cfgReg.pickup),
            .prolongTicks(cfgReg.prolong),
            .active(biActive[p])
        );
    end

    // differential trips skip the timers entirely
    assign txNext = ({ITR_PHASES{cfgReg.sendDiff}} & diffTrip)
        | biActive;

    // transmit commands and their indications per phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            txCmd <= '0;
            txCmdInd <= '0;
        end else begin
            txCmd <= txNext;
            txCmdInd <= txNext;
        end
    end

    // ------------------------------------------------------------
    // receive path
    // ------------------------------------------------------------
    // reaction decode
    assign reactTrip = (cfgReg.react == ITR_REACT_TRIP);
    // phase count picks single or three pole
    assign rxCount = 2'(rxCmd[0]) + 2'(rxCmd[1]) + 2'(rxCmd[2]);

    // received indications always, trip or alarm by reaction
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxCmdInd <= '0;
            tripForward <= '0;
            rxAlarm <= '0;
        end else begin
            rxCmdInd <= rxCmd;
            // the common trip logic decides on single-pole tripping
            tripForward <= reactTrip ? rxCmd : '0;
            rxAlarm <= reactTrip ? '0 : rxCmd;
        end
    end

    // trip indications: one phase alone is single-pole, more is three
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tripInd <= '0;
        end else begin
            tripInd.general <= reactTrip && rxCount != 2'h0;
            tripInd.onlyPhase <= (reactTrip && rxCount == 2'h1)
                ? rxCmd : '0;
            tripInd.threePhase <= reactTrip && rxCount > 2'h1;
            tripInd.singlePole <= reactTrip && rxCount == 2'h1;
            tripInd.threePole <= reactTrip && rxCount > 2'h1;
        end
    end

    // ------------------------------------------------------------
    // events and interrupt
    // ------------------------------------------------------------
    // remember last levels to find rising edges
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxSeenReg <= '0;
            txSeenReg <= '0;
        end else begin
            rxSeenReg <= rxCmd;
            txSeenReg <= txNext;
        end
    end

    // rising command edges are the events
    assign events[ITR_EVT_RX_LSB +: ITR_PHASES] = rxCmd & ~rxSeenReg;
    assign events[ITR_EVT_TX_LSB +: ITR_PHASES] = txNext & ~txSeenReg;

    // a read clears, but an event in the same cycle still sets
    always_comb begin
        statusNext = statusReg;
        if (rdStatus) begin
            statusNext = '0;
        end
        statusNext = statusNext | events;
    end

    // sticky status
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            statusReg <= '0;
        end else begin
            statusReg <= statusNext;
        end
    end

    // level interrupt registered from the next status (statusNext) and the mask
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(statusNext & maskReg);
        end
    end
endmodule

`default_nettype wire

// File: design/itr_pkg.sv
`default_nettype none

package itr_pkg;

    // ------------------------------------------------------------
    // clock and time base
    // ------------------------------------------------------------
    localparam int ITR_CLK_HZ = 40_000_000;
    localparam int ITR_TICK_MS = 10;
    localparam int ITR_TICK_CYCLES = ITR_CLK_HZ / 1000 * ITR_TICK_MS;

    // ------------------------------------------------------------
    // timer settings, in ticks of the time base
    // ------------------------------------------------------------
    localparam int ITR_TIME_W = 12;
    localparam logic [11:0] ITR_TIME_MAX = 12'hBB8;     // 30.00 s
    localparam logic [11:0] ITR_PICKUP_RST = 12'h002;   // 0.02 s
    localparam logic [11:0] ITR_PROLONG_RST = 12'h000;  // 0.00 s

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    localparam int ITR_ADDR_W = 8;
    localparam int ITR_DATA_W = 32;
    localparam logic [7:0] ITR_OFS_CTRL = 8'h00;
    localparam logic [7:0] ITR_OFS_PICKUP = 8'h04;
    localparam logic [7:0] ITR_OFS_PROLONG = 8'h08;
    localparam logic [7:0] ITR_OFS_STATUS = 8'h0C;
    localparam logic [7:0] ITR_OFS_MASK = 8'h10;
    localparam logic [7:0] ITR_OFS_STATE = 8'h14;

    // control register fields
    localparam int ITR_CTRL_SEND_BIT = 0;
    localparam int ITR_CTRL_ALARM_BIT = 1;

    // event layout: rx phases low, tx phases above
    localparam int ITR_PHASES = 3;
    localparam int ITR_EVT_W = 6;
    localparam int ITR_EVT_RX_LSB = 0;
    localparam int ITR_EVT_TX_LSB = 3;
    localparam int ITR_STATE_GEN_BIT = 6;

    // reaction to a received command
    typedef enum logic {
        ITR_REACT_TRIP,
        ITR_REACT_ALARM
    } itr_react_t;

    // live settings handed to the phase timers and routing
    typedef struct packed {
        logic sendDiff;
        itr_react_t react;
        logic [ITR_TIME_W-1:0] pickup;
        logic [ITR_TIME_W-1:0] prolong;
    } itr_cfg_t;

    // trip indications toward the common trip logic and display
    typedef struct packed {
        logic general;
        logic [ITR_PHASES-1:0] onlyPhase;
        logic threePhase;
        logic singlePole;
        logic threePole;
    } itr_trip_ind_t;

endpackage

`default_nettype wire

// File: design/itr_pin_sync.sv
`default_nettype none

// ------------------------------------------------------------
// three-stage pin synchroniser; a change is taken once the
// second and third stages agree
// ------------------------------------------------------------
module itr_pin_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1Reg; // metastable stage, read by stage2 only
    logic [WIDTH-1:0] stage2Reg;
    logic [WIDTH-1:0] stage3Reg;

    // shift the pins through the chain
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1Reg <= '0;
            stage2Reg <= '0;
            stage3Reg <= '0;
        end else begin
            stage1Reg <= pinIn;
            stage2Reg <= stage1Reg;
            stage3Reg <= stage2Reg;
        end
    end

    // per bit: only an agreed level moves the output
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            syncOut <= '0;
        end else begin
            syncOut <= (syncOut & (stage2Reg ^ stage3Reg))
                | (stage3Reg & ~(stage2Reg ^ stage3Reg));
        end
    end
endmodule

`default_nettype wire

// File: design/itr_phase_timer.sv
`default_nettype none

// ------------------------------------------------------------
// pickup delay followed by prolongation, counted in base ticks
// ------------------------------------------------------------
module itr_phase_timer #(
    parameter int TW = 12
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic reqIn,
    input wire logic [TW-1:0] pickupTicks,
    input wire logic [TW-1:0] prolongTicks,
    output logic active
);
    logic [TW-1:0] pickCntReg; // ticks seen while request is high
    logic [TW-1:0] prolCntReg; // ticks seen since request qualified off
    logic qualified;

    // a request counts only once it has outlasted the delay
    assign qualified = reqIn && (pickCntReg >= pickupTicks);

    // pickup counter restarts on any drop, which filters glitches
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pickCntReg <= '0;
        end else if (!reqIn) begin
            pickCntReg <= '0;
        end else if (tick && pickCntReg < pickupTicks) begin
            pickCntReg <= pickCntReg + 1'b1;
        end
    end

    // prolongation counter runs while the qualified request is gone
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prolCntReg <= '0;
        end else if (qualified) begin
            prolCntReg <= '0;
        end else if (active && tick) begin
            prolCntReg <= prolCntReg + 1'b1;
        end
    end

    // output holds until the prolongation has expired
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            active <= 1'b0;
        end else if (qualified) begin
            active <= 1'b1;
        end else if (prolCntReg >= prolongTicks) begin
            active <= 1'b0;
        end
    end
endmodule

`default_nettype wire

// File: test/itr_intertrip_logic_asserts.sv
`default_nettype none

// ----------------------------------------
// port checker for the intertrip block
// ----------------------------------------
module itr_intertrip_logic_asserts
    import itr_pkg::*;
#(
    parameter int TICK_CYCLES = 10
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [itr_pkg::ITR_ADDR_W-1:0] regAddr,
    input wire logic [itr_pkg::ITR_DATA_W-1:0] regWrData,
    input wire logic regWrStrobe,
    input wire logic [itr_pkg::ITR_PHASES-1:0] diffTrip,
    input wire logic [itr_pkg::ITR_PHASES-1:0] rxCmd,
    input wire logic [itr_pkg::ITR_PHASES-1:0] txCmd,
    input wire logic [itr_pkg::ITR_PHASES-1:0] rxCmdInd,
    input wire logic [itr_pkg::ITR_PHASES-1:0] txCmdInd,
    input wire logic [itr_pkg::ITR_PHASES-1:0] tripForward,
    input wire logic [itr_pkg::ITR_PHASES-1:0] rxAlarm,
    input wire itr_pkg::itr_trip_ind_t tripInd
);
    timeunit 1ns;
    timeprecision 1ps;

    logic sendDiff; // shadow of the diff send enable
    logic alarmOnly; // shadow of the receive reaction

    // follow control writes; the block takes them on the same edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sendDiff <= 1'b0;
            alarmOnly <= 1'b0;
        end else if (regWrStrobe && regAddr == ITR_OFS_CTRL) begin
            sendDiff <= regWrData[ITR_CTRL_SEND_BIT];
            alarmOnly <= regWrData[ITR_CTRL_ALARM_BIT];
        end
    end

    // ----------------------------------------
    // assertions, one clock domain
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    diff_pass_a: assert property (sendDiff |=>
        (txCmd & $past(diffTrip)) == $past(diffTrip))
        else $error("diff trip not passed to transmit");
    sent_ind_a: assert property (txCmdInd == txCmd)
        else $error("sent indication off");
    recv_ind_a: assert property (1'b1 |=> rxCmdInd == $past(rxCmd))
        else $error("received indication off");
    trip_fwd_a: assert property (!alarmOnly |=> tripForward == $past(rxCmd))
        else $error("trip not forwarded");
    alarm_only_a: assert property (alarmOnly |=>
        rxAlarm == $past(rxCmd) && tripForward == 3'h0)
        else $error("alarm reaction off");
    general_trip_a: assert property (!alarmOnly && rxCmd != 3'h0 |=> tripInd.general)
        else $error("general trip missing");
    one_phase_a: assert property (!alarmOnly && $onehot(rxCmd) |=>
        tripInd.singlePole && !tripInd.threePole && tripInd.onlyPhase == $past(rxCmd))
        else $error("single phase trip off");
    multi_phase_a: assert property (!alarmOnly && !$onehot0(rxCmd) |=>
        tripInd.threePhase && tripInd.threePole && tripInd.onlyPhase == 3'h0)
        else $error("three phase trip off");

    // main scenarios reached
    cover property (sendDiff && diffTrip != 3'h0);
    cover property (!alarmOnly && $onehot(rxCmd));
    cover property (alarmOnly && rxCmd != 3'h0);
endmodule

bind itr_intertrip_logic itr_intertrip_logic_asserts #(.TICK_CYCLES(TICK_CYCLES))
    itr_intertrip_logic_asserts_inst (.clk, .rst, .regAddr, .regWrData, .regWrStrobe,
    .diffTrip, .rxCmd, .txCmd, .rxCmdInd, .txCmdInd, .tripForward, .rxAlarm, .tripInd);

`default_nettype wire

// File: test/itr_remote_model.sv
`default_nettype none

// ----------------------------------------
// far relay: sends commands, records what arrives
// ----------------------------------------
module itr_remote_model
    import itr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [itr_pkg::ITR_PHASES-1:0] txCmd,
    input wire logic [itr_pkg::ITR_PHASES-1:0] sendReq,
    input wire logic clrSeen,
    output logic [itr_pkg::ITR_PHASES-1:0] rxCmd,
    output logic [itr_pkg::ITR_PHASES-1:0] seenTx
);
    timeunit 1ns;
    timeprecision 1ps;

    // one link cycle of latency; each phase travels on its own bit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxCmd <= 3'h0;
        end else begin
            rxCmd <= sendReq;
        end
    end

    // sticky record, so a short blip on the link is never missed
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seenTx <= 3'h0;
        end else if (clrSeen) begin
            seenTx <= 3'h0;
        end else begin
            seenTx <= seenTx | txCmd;
        end
    end
endmodule

`default_nettype wire

// File: test/tb_itr_intertrip_logic.sv
`default_nettype none

module tb_itr_intertrip_logic import itr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TICKS = 10; // short time base keeps the run brief
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic regWrStrobe = 1'b0;
    logic regRdStrobe = 1'b0;
    logic [31:0] regRdData;
    logic irq;
    logic [2:0] diffTrip = 3'h0;
    logic [2:0] pins = 3'h0; // per-phase input pins
    logic allPins = 1'b0; // three-pole input pin
    logic [2:0] sendReq = 3'h0; // commands the far relay sends
    logic clrSeen = 1'b0;
    logic [2:0] rxCmd, txCmd, rxCmdInd, txCmdInd, tripForward, rxAlarm, seenTx;
    itr_trip_ind_t tripInd;
    int fail_count = 0;
    int num_checks = 0;

    itr_intertrip_logic #(.TICK_CYCLES(TICKS)) itr_intertrip_logic_inst (.clk, .rst,
        .regAddr, .regWrData, .regWrStrobe, .regRdStrobe, .regRdData, .irq, .diffTrip,
        .remoteTripInPhase(pins), .remoteTripInAllPhases(allPins), .rxCmd, .txCmd,
        .rxCmdInd, .txCmdInd, .tripForward, .rxAlarm, .tripInd);
    itr_remote_model itr_remote_model_inst (.clk, .rst, .txCmd, .sendReq, .clrSeen,
        .rxCmd, .seenTx);

    // ----------------------------------------
    // clock, compare and bus tasks
    // ----------------------------------------
    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic conclude();
        if (fail_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrStrobe <= 1'b1;
        @(posedge clk);
        regWrStrobe <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe, so look there
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        regAddr <= a;
        regRdStrobe <= 1'b1;
        @(posedge clk);
        regRdStrobe <= 1'b0;
        #1;
        chk(regRdData, exp, what);
    endtask

    // settle just after an edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // hang guard, far beyond the few hundred cycles needed
    initial begin
        repeat (4000) @(posedge clk);
        fail_count++;
        conclude();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(ITR_OFS_CTRL, 32'h0, "ctrl reset value");
        rd(ITR_OFS_PICKUP, 32'h2, "pickup reset value");
        rd(ITR_OFS_PROLONG, 32'h0, "prolong reset value");
        rd(8'h20, 32'h0, "unmapped read");
        wr(8'h20, 32'hFFFFFFFF);
        wr(ITR_OFS_PICKUP, 32'hFFF);
        rd(ITR_OFS_PICKUP, {20'h0, ITR_TIME_MAX}, "pickup not clamped");
        // diff trips stay home while sending is off
        @(posedge clk);
        diffTrip <= 3'h5;
        step(4);
        chk(txCmd, 32'h0, "diff sent while off");
        @(posedge clk);
        diffTrip <= 3'h0;
        wr(ITR_OFS_MASK, 32'h3F);
        rd(ITR_OFS_MASK, 32'h3F, "mask readback");
        wr(ITR_OFS_CTRL, 32'h1);
        rd(ITR_OFS_STATUS, 32'h0, "status not idle");
        @(posedge clk);
        diffTrip <= 3'h2;
        step(1);
        chk(txCmd, 32'h2, "diff not passed at once");
        step(1);
        chk(irq, 32'h1, "irq not raised");
        rd(ITR_OFS_STATUS, 32'h10, "sent event missing");
        step(1);
        chk(irq, 32'h0, "irq not cleared");
        // a masked event is kept but does not interrupt
        @(posedge clk);
        diffTrip <= 3'h0;
        wr(ITR_OFS_MASK, 32'h0);
        @(posedge clk);
        diffTrip <= 3'h1;
        step(3);
        chk(irq, 32'h0, "masked irq raised");
        rd(ITR_OFS_STATUS, 32'h8, "masked event lost");
        @(posedge clk);
        diffTrip <= 3'h0;
        wr(ITR_OFS_CTRL, 32'h0);
        // pin path: 3 ticks of pickup, 2 of prolongation
        wr(ITR_OFS_PICKUP, 32'h3);
        wr(ITR_OFS_PROLONG, 32'h2);
        @(posedge clk);
        pins <= 3'h4;
        step(18);
        chk(txCmd, 32'h0, "sent before pickup");
        step(32);
        chk(txCmd, 32'h4, "phase pin not sent");
        @(posedge clk);
        pins <= 3'h0;
        step(10);
        chk(txCmd, 32'h4, "not prolonged");
        step(35);
        chk(txCmd, 32'h0, "prolonged too long");
        // a pulse shorter than the pickup must never leave
        @(posedge clk);
        clrSeen <= 1'b1;
        pins <= 3'h1;
        @(posedge clk);
        clrSeen <= 1'b0;
        repeat (11) @(posedge clk);
        pins <= 3'h0;
        step(40);
        chk(seenTx, 32'h0, "short pulse sent");
        @(posedge clk);
        allPins <= 1'b1;
        step(50);
        chk(txCmd, 32'h7, "three-pole pin not sent");
        chk(txCmdInd, 32'h7, "sent indication off");
        chk(seenTx, 32'h7, "far end missed command");
        @(posedge clk);
        allPins <= 1'b0;
        step(50);
        // receive side, trip reaction
        @(posedge clk);
        sendReq <= 3'h1;
        step(2);
        chk(tripForward, 32'h1, "trip not forwarded");
        chk(tripInd, 32'h4A, "single phase indications");
        @(posedge clk);
        sendReq <= 3'h6;
        step(2);
        chk(rxCmdInd, 32'h6, "received indication off");
        chk(tripInd, 32'h45, "three phase indications");
        // alarm only: nothing reaches the trip logic
        wr(ITR_OFS_CTRL, 32'h2);
        @(posedge clk);
        sendReq <= 3'h3;
        step(2);
        chk(rxAlarm, 32'h3, "alarm missing");
        chk({tripForward, tripInd}, 32'h0, "tripped in alarm mode");
        rd(ITR_OFS_STATE, 32'h3, "state readback");
        rd(ITR_OFS_STATUS, 32'h3F, "rx events missing");
        @(posedge clk);
        sendReq <= 3'h0;
        step(2);
        conclude();
    end
endmodule

`default_nettype wire
